// ### rtl/fgc_top.sv
/*
 * Filter and gain configuration register with its three-wire serial port.
 * Holds one 8-bit word that sets the filter corner and three gain steps
 * shared by both signal channels. Assumes a host that drives the strobe,
 * the serial clock and the data line, and a 40 MHz system clock with a
 * synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

// Operation
// - One stored 8-bit frequency and gain word.
// - Frequency code n selects n MHz bandwidth.
// - Upper five bits; code zero passes nothing.
// - Lowest three bits form the digital gain code.
// - Preamp bit chooses 3 or 6 dB.
// - Postamp bit chooses 6 or 12 dB.
// - VGA bit chooses 22 or 28 dB maximum.
// - Both channels share the one setting.
// - Chip enable low fully disables the device; the code still answers serial reads.
// - Strobe low, first rising edge: write or read.
// - Write: eight bits LSB first on rising edges.
// - Strobe rising after a write applies new word.
// - Read: word out LSB first on falling edges.
module fgc_top
    import fgc_pkg::*;
(
    // System clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Serial port pins.
    input  wire logic       spi_clk,
    input  wire logic       frame_strobe,
    input  wire logic       serial_data_in,
    output logic            serial_readback_out,
    // Enable pin.
    input  wire logic       chip_on_input,
    // Controls to the analog path, shared by both channels.
    output logic            device_enabled,
    output logic [4:0]      filter_corner_mhz,
    output logic            filter_pass,
    output logic [2:0]      digital_gain_code,
    output logic            preamp_gain_select,
    output logic            postamp_gain_select,
    output logic            vga_max_gain_select,
    // Stored word as seen by the core.
    output logic [7:0]      config_word
);

    fgc_link_if lnk ();

    fgc_serial_link u_link (
        .spi_clk             (spi_clk),
        .frame_strobe        (frame_strobe),
        .serial_data_in      (serial_data_in),
        .serial_readback_out (serial_readback_out),
        .lnk                 (lnk.link)
    );

    // Pins from outside this clock domain pass two flip-flops first.
    logic       strb_s1_q;
    logic       strb_s2_q;
    logic       strb_s3_q;
    logic       done_s1_q;
    logic       done_s2_q;
    logic       en_s1_q;
    logic       en_s2_q;
    logic       pending_q;
    logic       pending_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic       en_q;
    logic [4:0] freq_q;
    logic       pass_q;
    logic [2:0] dgain_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strb_s1_q <= STROBE_IDLE;
            strb_s2_q <= STROBE_IDLE;
            strb_s3_q <= STROBE_IDLE;
            done_s1_q <= LOW;
            done_s2_q <= LOW;
            en_s1_q   <= LOW;
            en_s2_q   <= LOW;
        end else begin
            strb_s1_q <= frame_strobe;
            strb_s2_q <= strb_s1_q;
            strb_s3_q <= strb_s2_q;
            done_s1_q <= lnk.wr_done;
            done_s2_q <= done_s1_q;
            en_s1_q   <= chip_on_input;
            en_s2_q   <= en_s1_q;
        end
    end

    wire strobe_rise = strb_s2_q && !strb_s3_q;
    wire strobe_fall = !strb_s2_q && strb_s3_q;
    wire write_ok    = pending_q || done_s2_q;
    // The strobe clears the link's done flag at the moment it rises, and the
    // two synchronisers may resolve a cycle apart, so completion is latched.
    wire apply_wr    = strobe_rise && write_ok && en_s2_q;

    assign pending_d = (strobe_rise || strobe_fall) ? LOW :
                       (done_s2_q ? 1'b1 : pending_q);
    // The link word stays still from its last bit until the next full write,
    // so it is safe to take it here once the strobe has risen.
    assign cfg_d     = apply_wr ? lnk.wr_word : cfg_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending_q <= LOW;
            cfg_q     <= CFG_RESET;
        end else begin
            pending_q <= pending_d;
            cfg_q     <= cfg_d;
        end
    end

    // A disabled device drives every control to its off value.
    wire [4:0] freq_field  = cfg_q[FREQ_MSB:FREQ_LSB];
    wire [4:0] freq_eff    = en_s2_q ? freq_field : FREQ_NONE;
    wire [2:0] dgain_field = cfg_q[DGAIN_MSB:0];
    wire [2:0] dgain_eff   = en_s2_q ? dgain_field : 3'h0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_q    <= LOW;
            freq_q  <= FREQ_NONE;
            pass_q  <= LOW;
            dgain_q <= 3'h0;
        end else begin
            en_q    <= en_s2_q;
            freq_q  <= freq_eff;
            pass_q  <= (freq_eff != FREQ_NONE);
            dgain_q <= dgain_eff;
        end
    end

    // One set of controls feeds both channels; there is no per-channel copy.
    assign device_enabled      = en_q;
    assign filter_corner_mhz   = freq_q;
    assign filter_pass         = pass_q;
    assign digital_gain_code   = dgain_q;
    assign preamp_gain_select  = dgain_q[PRE_BIT];
    assign postamp_gain_select = dgain_q[POST_BIT];
    assign vga_max_gain_select = dgain_q[VGA_BIT];
    assign config_word         = cfg_q;
    assign lnk.cfg_word        = cfg_q;

endmodule

`default_nettype wire

// ### rtl/fgc_pkg.sv
/*
 * Constants for the filter and gain configuration block: word layout,
 * serial frame counts and the power-on value of the configuration word.
 * Assumes nothing of its surroundings; fgc_top and fgc_serial_link import it whole, fgc_link_if does not.
 */
package fgc_pkg;

    // Configuration word layout.
    localparam int unsigned CFG_W        = 8;
    localparam int unsigned FREQ_W       = 5;
    localparam int unsigned FREQ_LSB     = 3;
    localparam int unsigned FREQ_MSB     = 7;
    localparam int unsigned DGAIN_W      = 3;
    localparam int unsigned DGAIN_MSB    = 2;
    localparam int unsigned PRE_BIT      = 2;
    localparam int unsigned POST_BIT     = 1;
    localparam int unsigned VGA_BIT      = 0;

    // Power-on value of the word; zero means the filters pass no signal.
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [4:0]  FREQ_NONE    = 5'h00;

    // Serial frame: the command bit, then eight data bits.
    localparam logic        CMD_WRITE    = 1'b1;
    localparam int unsigned CNT_W        = 4;
    localparam logic [3:0]  CNT_CMD      = 4'h0;
    localparam logic [3:0]  CNT_FIRST    = 4'h1;
    localparam logic [3:0]  CNT_LAST     = 4'h8;
    localparam logic [3:0]  CNT_DONE     = 4'h9;
    localparam logic [3:0]  CNT_STEP     = 4'h1;

    // Reset levels of the synchronised pins.
    localparam logic        STROBE_IDLE  = 1'b1;
    localparam logic        LOW          = 1'b0;

endpackage

// ### rtl/fgc_link_if.sv
/*
 * Carrier between the serial link logic and the configuration core.
 * Assumes wr_word is quasi-static once wr_done is high and cfg_word only
 * changes while no frame is active.
 */
`timescale 1ns/100ps
`default_nettype none

interface fgc_link_if;
    logic [7:0] wr_word;
    logic       wr_done;
    logic [7:0] cfg_word;

    modport link (
        output wr_word,
        output wr_done,
        input  cfg_word
    );

    modport core (
        input  wr_word,
        input  wr_done,
        output cfg_word
    );
endinterface

`default_nettype wire

// ### rtl/fgc_serial_link.sv
/*
 * Serial port logic running on the host's serial clock. Decodes the
 * command bit, shifts in write data and shifts out the stored word.
 * Assumes the serial clock only runs while the frame strobe is low; a high
 * strobe clears all frame control asynchronously.
 */
`timescale 1ns/100ps
`default_nettype none

module fgc_serial_link
    import fgc_pkg::*;
(
    // Serial pins.
    input  wire logic   spi_clk,
    input  wire logic   frame_strobe,
    input  wire logic   serial_data_in,
    output logic        serial_readback_out,
    // Core side.
    fgc_link_if.link    lnk
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       is_wr_q;
    logic       done_q;
    logic       rb_q;
    logic [7:0] sh_q;
    logic [7:0] hold_q;

    wire        at_cmd    = (cnt_q == CNT_CMD);
    wire        in_data   = (cnt_q >= CNT_FIRST) && (cnt_q <= CNT_LAST);
    wire        shift_en  = in_data && is_wr_q;
    wire        last_bit  = shift_en && (cnt_q == CNT_LAST);
    wire [7:0]  sh_next   = {serial_data_in, sh_q[7:1]};
    wire [2:0]  rd_idx    = 3'(cnt_q - CNT_FIRST);
    wire        rd_bit    = (in_data && !is_wr_q) ? lnk.cfg_word[rd_idx] : LOW;

    assign cnt_d = (cnt_q == CNT_DONE) ? cnt_q : 4'(cnt_q + CNT_STEP);

    // Bits beyond the eighth are ignored: the counter parks at CNT_DONE.
    always_ff @(posedge spi_clk or posedge frame_strobe) begin
        if (frame_strobe) begin
            cnt_q   <= CNT_CMD;
            is_wr_q <= LOW;
            done_q  <= LOW;
        end else begin
            cnt_q <= cnt_d;
            if (at_cmd) begin
                is_wr_q <= (serial_data_in == CMD_WRITE);
            end
            if (last_bit) begin
                done_q <= 1'b1;
            end
        end
    end

    // Data bits arrive LSB first, so they enter at the top and move down.
    always_ff @(posedge spi_clk) begin
        if (shift_en) begin
            sh_q <= sh_next;
        end
        if (last_bit) begin
            hold_q <= sh_next;
        end
    end

    // The falling edge after the command edge presents bit 0.
    always_ff @(negedge spi_clk or posedge frame_strobe) begin
        if (frame_strobe) begin
            rb_q <= LOW;
        end else begin
            rb_q <= rd_bit;
        end
    end

    assign serial_readback_out = rb_q;
    assign lnk.wr_word         = hold_q;
    assign lnk.wr_done         = done_q;

endmodule

`default_nettype wire

// ### tb/fgc_properties.sv
/* Port checker for fgc_top, bound to the top module.
   Assumes sys_clk and its synchronous reset rst. */
`timescale 1ns/100ps
`default_nettype none
module fgc_properties (
    // Clock, reset and pins.
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       frame_strobe,
    input wire logic       chip_on_input,
    input wire logic       serial_readback_out,
    // Controls and stored word.
    input wire logic       device_enabled,
    input wire logic [4:0] filter_corner_mhz,
    input wire logic       filter_pass,
    input wire logic [2:0] digital_gain_code,
    input wire logic       preamp_gain_select,
    input wire logic       postamp_gain_select,
    input wire logic       vga_max_gain_select,
    input wire logic [7:0] config_word
);
    logic [7:0] cfg_prev_q;
    always_ff @(posedge sys_clk) begin
        cfg_prev_q <= config_word;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_off_zero: assert property (!device_enabled |-> filter_corner_mhz == 5'h00)
        else $error("corner code active while disabled");
    a_corner_code: assert property (device_enabled |-> filter_corner_mhz == cfg_prev_q[7:3])
        else $error("corner code differs from stored word");
    a_pass_flag: assert property (filter_pass == (filter_corner_mhz != 5'h00))
        else $error("pass flag wrong for corner code");
    a_gain_code: assert property (device_enabled |-> digital_gain_code == cfg_prev_q[2:0])
        else $error("gain code differs from stored word");
    a_gain_bits: assert property ({preamp_gain_select, postamp_gain_select,
        vga_max_gain_select} == digital_gain_code) else $error("gain selects split wrongly");
    a_enable_lag: assert property ($changed(device_enabled) |->
        device_enabled == $past(chip_on_input, 3)) else $error("enable lag wrong");
    a_word_settle: assert property ($changed(config_word) |->
        frame_strobe && $past(frame_strobe, 3)) else $error("word changed inside a frame");
    a_read_idle: assert property (frame_strobe && $past(frame_strobe) |->
        !serial_readback_out) else $error("readback driven outside a frame");
endmodule
bind fgc_top fgc_properties u_props (.sys_clk, .rst, .frame_strobe, .chip_on_input,
    .serial_readback_out, .device_enabled, .filter_corner_mhz, .filter_pass,
    .digital_gain_code, .preamp_gain_select, .postamp_gain_select, .vga_max_gain_select,
    .config_word);
`default_nettype wire

// ### tb/fgc_host.sv
/* Serial host model that frames writes and reads on the three-wire port.
   Assumes the device samples on rising and shifts out on falling clock. */
`timescale 1ns/100ps
`default_nettype none
module fgc_host (
    // Serial pins.
    output logic      spi_clk,
    output logic      frame_strobe,
    output logic      serial_data_in,
    input  wire logic serial_readback_out
);
    initial begin
        spi_clk = 1'b0;
        frame_strobe = 1'b1;
        serial_data_in = 1'b0;
    end
    // The clock stands still between frames; the idle data line flips so stale bits show.
    task automatic xfer(input logic wr, input logic [7:0] w, input int n, output logic [7:0] r);
        r = 8'h00;
        frame_strobe = 1'b0;
        for (int i = 0; i <= n; i++) begin
            serial_data_in = (i == 0) ? wr : w[i-1];
            #40 spi_clk = 1'b1;
            #80 spi_clk = 1'b0;
            #40 if (i < 8) r[i] = serial_readback_out;
        end
        #120 frame_strobe = 1'b1;
        serial_data_in = ~serial_data_in;
        #200;
    endtask
endmodule
`default_nettype wire

// ### tb/filter_gain_config_register_tb.sv
/* Self-checking bench for fgc_top driven by the serial host model.
   Assumes a 40 MHz system clock; the host makes the serial clock. */
`timescale 1ns/100ps
`default_nettype none
module filter_gain_config_register_tb;
    import fgc_pkg::*;
    logic       sys_clk, rst, chip_on_input, spi_clk, frame_strobe, serial_data_in;
    logic       serial_readback_out, device_enabled, filter_pass;
    logic       preamp_gain_select, postamp_gain_select, vga_max_gain_select;
    logic [4:0] filter_corner_mhz;
    logic [2:0] digital_gain_code;
    logic [7:0] config_word, rd, gains;
    int         n_mismatch = 0, num_checks = 0;
    assign gains = {2'h0, preamp_gain_select, postamp_gain_select, vga_max_gain_select,
                    digital_gain_code};
    fgc_top dut (.sys_clk, .rst, .spi_clk, .frame_strobe, .serial_data_in, .serial_readback_out,
        .chip_on_input, .device_enabled, .filter_corner_mhz, .filter_pass, .digital_gain_code,
        .preamp_gain_select, .postamp_gain_select, .vga_max_gain_select, .config_word);
    fgc_host host (.spi_clk, .frame_strobe, .serial_data_in, .serial_readback_out);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] w, input int n);
        host.xfer(wr, w, n, rd);
        @(posedge sys_clk);
        #2;
    endtask
    task automatic t_codes;
        logic [7:0] tbl [4] = '{8'hA5, 8'h07, 8'hFF, 8'h0A};
        chk(config_word, CFG_RESET);
        chk({7'h00, device_enabled}, 8'h01);
        foreach (tbl[i]) begin
            xfer(CMD_WRITE, tbl[i], 8);
            chk(config_word, tbl[i]);
            chk({3'h0, filter_corner_mhz}, {3'h0, tbl[i][7:3]});
            chk({7'h00, filter_pass}, {7'h00, tbl[i][7:3] != 5'h00});
            chk(gains, {2'h0, tbl[i][2:0], tbl[i][2:0]});
            xfer(~CMD_WRITE, 8'h00, 8);
            chk(rd, tbl[i]);
            chk(config_word, tbl[i]);
        end
    endtask
    task automatic t_short_write;
        xfer(CMD_WRITE, 8'h3C, 7);
        chk(config_word, 8'h0A);
    endtask
    task automatic t_disable;
        chip_on_input = 1'b0;
        repeat (3) @(posedge sys_clk);
        #2;
        chk({device_enabled, filter_corner_mhz, filter_pass, |gains}, 8'h00);
        xfer(CMD_WRITE, 8'h81, 8);
        chk(config_word, 8'h0A);
        chip_on_input = 1'b1;
        repeat (3) @(posedge sys_clk);
        #2;
        chk({3'h0, filter_corner_mhz}, 8'h01);
        chk({7'h00, device_enabled}, 8'h01);
        chk(gains, {2'h0, 3'h2, 3'h2});
    endtask
    initial begin
        rst = 1'b1;
        chip_on_input = 1'b1;
        repeat (12) @(posedge sys_clk);
        #2 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #2;
        t_codes();
        t_short_write();
        t_disable();
        report_and_stop();
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
